// ---- common/dag_pkg.sv ----
// Purpose: shared constants and types of the dual address generator
// Assumes: one core clock, registers reached over AXI4-Lite
// Notes: op codes are one-hot; each decode compares the whole six-bit kind field
`default_nettype none
package dag_pkg;
    localparam int DM_W = 32;
    localparam int PM_W = 24;
    localparam int BUS_W = 40;
    localparam int BUS_LSB = 8;
    localparam int WAIT_W = 3;
    // interrupt vectors; the mask bit of each is its vector divided by four
    localparam int VEC_DM_WRAP = 32'h58;
    localparam int VEC_PM_WRAP = 32'h60;
    localparam int MASK_DM_BIT = VEC_DM_WRAP / 4;
    localparam int MASK_PM_BIT = VEC_PM_WRAP / 4;
    localparam int STICKY_STATUS_DM_BIT = 17;
    localparam int STICKY_STATUS_PM_BIT = 18;
    localparam int MODE_BR0_BIT = 1;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_STICKY_STATUS = 8'h08;
    localparam logic [7:0] OFS_DM_LAST = 8'h0c;
    localparam logic [7:0] OFS_PM_LAST = 8'h10;
    localparam logic [31:0] RST_MODE = 32'h0000_0000;
    localparam logic [31:0] RST_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_WAIT = 32'h0000_0000;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        K_POST = 6'h01,
        K_PRE = 6'h02,
        K_BREV = 6'h04,
        K_RDREG = 6'h08,
        K_WRREG = 6'h10,
        K_WRCTL = 6'h20
    } dag_kind_t;

    typedef enum logic [1:0] {
        RC_I = 2'h0,
        RC_M = 2'h1,
        RC_B = 2'h2,
        RC_L = 2'h3
    } dag_rclass_t;

    typedef struct packed {
        dag_kind_t kind;
        logic pm;
        logic mem_wr;
        logic [2:0] idx;
        logic [2:0] msel;
        logic use_imm;
        logic [31:0] imm;
        dag_rclass_t rclass;
    } dag_op_t;
endpackage : dag_pkg
`default_nettype wire

// ---- verilog/dag_top.sv ----
// Purpose: data-memory and program-memory address generators with ring buffers
// Assumes: one op per cycle from the sequencer, held while o_stall is high
// Notes: all bus outputs are registered, one cycle after the op is taken
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - only dm set 7 and pm set 15 raise wrap interrupts, vectors 0x58, 0x60
// - on post-modify, overflow when below base (m<0) or at/after base+length
// - each wrap interrupt is gated by its own mask bit
// - overflow compare runs even with zero length
// - sticky bits 17/18 set on overflow, cleared by next access via I7/I15
// - mode bit 1 reverses the 32-bit address from index 0, pre and post
// - reversed addresses select dm bank 0 and its wait count
// - index 0 and its update stay unreversed
// - last dm address of a read or write access is kept for reading; reverse op addresses are not
// - reverse op adds immediate to dm index, reverses, stores back
// - reverse op drives address with no strobes
// - dm generator registers use data bus bits 39-8
// - pm reads sign-extend modify, zero-fill index, base, length
// - pm writes take data bus bits 31-8
// - register load then addressing in same generator stalls one cycle
// - memory control write then use of matching generator stalls one cycle
// - every pm control write is followed by a stall cycle
// - circular post-modify wraps by subtracting or adding the length
// - base write loads the index too; index write leaves base alone
// - zero length makes post-modify linear
// - pre-modify outputs index plus modifier, no write-back, always linear
module dag_top (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // sequencer op
    input wire logic i_op_valid,
    input wire dag_pkg::dag_op_t i_op,
    output logic o_stall,
    // register transfers
    input wire logic [dag_pkg::BUS_W-1:0] i_dm_data_bus,
    output logic [dag_pkg::BUS_W-1:0] o_dm_data_bus,
    // data memory address bus
    output logic [dag_pkg::DM_W-1:0] o_dm_addr,
    output logic o_dm_rd,
    output logic o_dm_wr,
    output logic [3:0] o_dm_bank_sel,
    output logic [dag_pkg::WAIT_W-1:0] o_dm_wait,
    // program memory address bus
    output logic [dag_pkg::PM_W-1:0] o_pm_addr,
    output logic o_pm_rd,
    output logic o_pm_wr,
    output logic [dag_pkg::WAIT_W-1:0] o_pm_wait,
    // interrupt requests
    output logic o_dm_ring_wrap_irq,
    output logic o_pm_ring_wrap_irq,
    // axi4-lite slave
    input wire logic [7:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [31:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [7:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [31:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready
);
    import dag_pkg::*;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);

    logic [31:0] dm_i_reg [8];
    logic [31:0] dm_m_reg [8];
    logic [31:0] dm_b_reg [8];
    logic [31:0] dm_l_reg [8];
    logic [23:0] pm_i_reg [8];
    logic [23:0] pm_m_reg [8];
    logic [23:0] pm_b_reg [8];
    logic [23:0] pm_l_reg [8];
    logic [31:0] mode_reg, mask_reg, dm_wait_reg, pm_wait_reg, dm_last_reg;
    logic [23:0] pm_last_reg;
    logic [1:0] sticky_status_reg, hazard_reg;
    logic pm_force_reg;

    ////////////////////////////////////////////////////////////////////////////
    // op decode and operand selection
    wire k_post = i_op.kind == K_POST;
    wire k_pre = i_op.kind == K_PRE;
    wire k_brev = i_op.kind == K_BREV;
    wire k_rdreg = i_op.kind == K_RDREG;
    wire k_wrreg = i_op.kind == K_WRREG;
    wire k_wrctl = i_op.kind == K_WRCTL;
    wire is_pm = i_op.pm;
    wire [2:0] ix = i_op.idx;
    wire [2:0] mx = i_op.msel;
    // reverse op always works on the dm generator
    wire use_gen = i_op_valid && (k_post || k_pre || k_brev);
    wire gen = k_brev ? 1'b0 : is_pm;
    assign o_stall = pm_force_reg || (use_gen && hazard_reg[gen]);
    wire take = i_op_valid && !o_stall;

    wire [31:0] cur_i = is_pm ? {8'h00, pm_i_reg[ix]} : dm_i_reg[ix];
    wire [31:0] cur_b = is_pm ? {8'h00, pm_b_reg[ix]} : dm_b_reg[ix];
    wire [31:0] cur_l = is_pm ? {8'h00, pm_l_reg[ix]} : dm_l_reg[ix];
    wire [31:0] cur_mreg = is_pm ? {{8{pm_m_reg[mx][23]}}, pm_m_reg[mx]} : dm_m_reg[mx];
    wire [31:0] imm_x = is_pm ? {{8{i_op.imm[23]}}, i_op.imm[23:0]} : i_op.imm;
    wire [31:0] cur_m = i_op.use_imm ? imm_x : cur_mreg;
    wire [31:0] amask = is_pm ? 32'h00ff_ffff : 32'hffff_ffff;

    ////////////////////////////////////////////////////////////////////////////
    // modify, wrap and overflow
    wire [31:0] sum = (cur_i + cur_m) & amask;
    wire [32:0] buf_end = {1'b0, cur_b} + {1'b0, cur_l};
    wire under = cur_m[31] && (sum < cur_b);
    wire over = !cur_m[31] && ({1'b0, sum} >= buf_end);
    wire [31:0] sum_dn = (sum - cur_l) & amask;
    wire [31:0] sum_up = (sum + cur_l) & amask;
    wire lin = cur_l == 32'h0;
    wire [31:0] wrapped = lin ? sum : over ? sum_dn : under ? sum_up : sum;
    wire post7 = take && k_post && ix == 3'h7;
    wire ovf_dm7 = post7 && !is_pm && (over || under);
    wire ovf_pm15 = post7 && is_pm && (over || under);

    ////////////////////////////////////////////////////////////////////////////
    // address output and bit reversal
    wire [31:0] raw_addr = k_pre ? sum : cur_i;
    wire brev_mode = !is_pm && ix == 3'h0 && mode_reg[MODE_BR0_BIT] && (k_post || k_pre);
    wire [31:0] brev_sum = dm_i_reg[ix] + i_op.imm;
    wire [31:0] rev_raw, rev_sum;
    for (genvar g = 0; g < DM_W; g++) begin : g_rev
        assign rev_raw[g] = raw_addr[DM_W-1-g];
        assign rev_sum[g] = brev_sum[DM_W-1-g];
    end
    wire mem_acc = take && (k_post || k_pre);
    wire dm_acc = mem_acc && !is_pm;
    wire pm_acc = mem_acc && is_pm;
    wire brev_op = take && k_brev;
    // mode reversal is only on the way out; post-modify write-back uses wrapped, never rev_raw
    wire [31:0] dm_out = k_brev ? rev_sum : brev_mode ? rev_raw : raw_addr;
    // bank from top address bits; a reversed address is too late to decode
    wire [1:0] bank = (k_brev || brev_mode) ? 2'h0 : dm_out[31:30];
    wire [3:0] bank_oh = 4'h1 << bank;
    wire [2:0] bank_wait = dm_wait_reg[bank*WAIT_W +: WAIT_W];

    ////////////////////////////////////////////////////////////////////////////
    // register transfers
    wire [31:0] dm_rd = i_op.rclass == RC_I ? dm_i_reg[ix] : i_op.rclass == RC_M ? dm_m_reg[ix]
        : i_op.rclass == RC_B ? dm_b_reg[ix] : dm_l_reg[ix];
    wire [23:0] pm_rd = i_op.rclass == RC_I ? pm_i_reg[ix] : i_op.rclass == RC_M ? pm_m_reg[ix]
        : i_op.rclass == RC_B ? pm_b_reg[ix] : pm_l_reg[ix];
    wire [31:0] pm_rd_x = i_op.rclass == RC_M ? {{8{pm_rd[23]}}, pm_rd} : {8'h00, pm_rd};
    wire [31:0] rd_val = is_pm ? pm_rd_x : dm_rd;
    wire [31:0] wr_val = is_pm ? {8'h00, i_dm_data_bus[31:BUS_LSB]}
        : i_dm_data_bus[BUS_W-1:BUS_LSB];
    wire reg_wr = take && k_wrreg;
    wire ctl_wr = take && k_wrctl;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int n = 0; n < 8; n++) begin
                dm_i_reg[n] <= 32'h0;
                dm_m_reg[n] <= 32'h0;
                dm_b_reg[n] <= 32'h0;
                dm_l_reg[n] <= 32'h0;
                pm_i_reg[n] <= 24'h0;
                pm_m_reg[n] <= 24'h0;
                pm_b_reg[n] <= 24'h0;
                pm_l_reg[n] <= 24'h0;
            end
        end else if (reg_wr && !is_pm) begin
            case (i_op.rclass)
                RC_I: dm_i_reg[ix] <= wr_val;
                RC_M: dm_m_reg[ix] <= wr_val;
                RC_B: begin
                    dm_b_reg[ix] <= wr_val;
                    dm_i_reg[ix] <= wr_val;
                end
                default: dm_l_reg[ix] <= wr_val;
            endcase
        end else if (reg_wr) begin
            case (i_op.rclass)
                RC_I: pm_i_reg[ix] <= wr_val[23:0];
                RC_M: pm_m_reg[ix] <= wr_val[23:0];
                RC_B: begin
                    pm_b_reg[ix] <= wr_val[23:0];
                    pm_i_reg[ix] <= wr_val[23:0];
                end
                default: pm_l_reg[ix] <= wr_val[23:0];
            endcase
        end else if (take && k_post && !is_pm) begin
            dm_i_reg[ix] <= wrapped;
        end else if (take && k_post) begin
            pm_i_reg[ix] <= wrapped[23:0];
        end else if (brev_op) begin
            dm_i_reg[ix] <= rev_sum;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // hazards, status and bus outputs
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            hazard_reg <= 2'h0;
            pm_force_reg <= 1'b0;
            sticky_status_reg <= 2'h0;
            dm_wait_reg <= RST_WAIT;
            pm_wait_reg <= RST_WAIT;
        end else begin
            hazard_reg[0] <= (reg_wr || ctl_wr) && !is_pm;
            hazard_reg[1] <= (reg_wr || ctl_wr) && is_pm;
            pm_force_reg <= ctl_wr && is_pm;
            // set wins over the clear when the same access through index 7 both overflows and clears
            sticky_status_reg[0] <= ovf_dm7 || (sticky_status_reg[0] && !(dm_acc && ix == 3'h7));
            sticky_status_reg[1] <= ovf_pm15 || (sticky_status_reg[1] && !(pm_acc && ix == 3'h7));
            if (ctl_wr && !is_pm) begin
                dm_wait_reg <= wr_val;
            end
            if (ctl_wr && is_pm) begin
                pm_wait_reg <= wr_val;
            end
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dm_addr <= 32'h0;
            o_dm_rd <= 1'b0;
            o_dm_wr <= 1'b0;
            o_dm_bank_sel <= 4'h0;
            o_dm_wait <= 3'h0;
            o_pm_addr <= 24'h0;
            o_pm_rd <= 1'b0;
            o_pm_wr <= 1'b0;
            o_pm_wait <= 3'h0;
            o_dm_data_bus <= 40'h0;
            o_dm_ring_wrap_irq <= 1'b0;
            o_pm_ring_wrap_irq <= 1'b0;
            dm_last_reg <= 32'h0;
            pm_last_reg <= 24'h0;
        end else begin
            o_dm_addr <= (dm_acc || brev_op) ? dm_out : o_dm_addr;
            o_dm_rd <= dm_acc && !i_op.mem_wr;
            o_dm_wr <= dm_acc && i_op.mem_wr;
            o_dm_bank_sel <= (dm_acc || brev_op) ? bank_oh : 4'h0;
            o_dm_wait <= bank_wait;
            o_pm_addr <= pm_acc ? raw_addr[23:0] : o_pm_addr;
            o_pm_rd <= pm_acc && !i_op.mem_wr;
            o_pm_wr <= pm_acc && i_op.mem_wr;
            o_pm_wait <= pm_wait_reg[WAIT_W-1:0];
            o_dm_data_bus <= (take && k_rdreg) ? {rd_val, 8'h00} : o_dm_data_bus;
            o_dm_ring_wrap_irq <= ovf_dm7 && mask_reg[MASK_DM_BIT];
            o_pm_ring_wrap_irq <= ovf_pm15 && mask_reg[MASK_PM_BIT];
            dm_last_reg <= dm_acc ? dm_out : dm_last_reg;
            pm_last_reg <= pm_acc ? raw_addr[23:0] : pm_last_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; address and data are taken together, one write at a time
    wire aw_take = i_s_axi_awvalid && i_s_axi_wvalid && !o_s_axi_bvalid;
    assign o_s_axi_awready = aw_take;
    assign o_s_axi_wready = aw_take;
    assign o_s_axi_arready = !o_s_axi_rvalid;
    wire ar_take = i_s_axi_arvalid && !o_s_axi_rvalid;
    wire [7:0] wa = {i_s_axi_awaddr[7:2], 2'h0};
    wire [7:0] ra = {i_s_axi_araddr[7:2], 2'h0};
    wire [31:0] wmask = {{8{i_s_axi_wstrb[3]}}, {8{i_s_axi_wstrb[2]}},
        {8{i_s_axi_wstrb[1]}}, {8{i_s_axi_wstrb[0]}}};
    wire [31:0] mode_new = (mode_reg & ~wmask) | (i_s_axi_wdata & wmask);
    wire [31:0] mask_new = (mask_reg & ~wmask) | (i_s_axi_wdata & wmask);
    wire w_ok = wa == OFS_MODE || wa == OFS_MASK;
    wire [31:0] sticky_status_word = ({31'h0, sticky_status_reg[0]} << STICKY_STATUS_DM_BIT)
        | ({31'h0, sticky_status_reg[1]} << STICKY_STATUS_PM_BIT);
    wire r_ok = ra == OFS_MODE || ra == OFS_MASK || ra == OFS_STICKY_STATUS
        || ra == OFS_DM_LAST || ra == OFS_PM_LAST;
    wire [31:0] r_word = ra == OFS_MODE ? mode_reg : ra == OFS_MASK ? mask_reg
        : ra == OFS_STICKY_STATUS ? sticky_status_word : ra == OFS_DM_LAST ? dm_last_reg
        : ra == OFS_PM_LAST ? {8'h00, pm_last_reg} : 32'h0;

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            mode_reg <= RST_MODE;
            mask_reg <= RST_MASK;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= AXI_OKAY;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rresp <= AXI_OKAY;
            o_s_axi_rdata <= 32'h0;
        end else begin
            mode_reg <= (aw_take && wa == OFS_MODE) ? mode_new : mode_reg;
            mask_reg <= (aw_take && wa == OFS_MASK) ? mask_new : mask_reg;
            o_s_axi_bvalid <= aw_take || (o_s_axi_bvalid && !i_s_axi_bready);
            o_s_axi_bresp <= aw_take ? (w_ok ? AXI_OKAY : AXI_SLVERR) : o_s_axi_bresp;
            o_s_axi_rvalid <= ar_take || (o_s_axi_rvalid && !i_s_axi_rready);
            o_s_axi_rresp <= ar_take ? (r_ok ? AXI_OKAY : AXI_SLVERR) : o_s_axi_rresp;
            o_s_axi_rdata <= ar_take ? r_word : o_s_axi_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_dm_irq_cause: assert property (o_dm_ring_wrap_irq |-> $past(ovf_dm7)
        && $past(mask_reg[MASK_DM_BIT])) else $error("dm wrap irq without cause");
    a_pm_irq_pulse: assert property (ovf_pm15 && mask_reg[MASK_PM_BIT]
        |=> o_pm_ring_wrap_irq) else $error("pm wrap irq missing");
    a_zero_len_ovf: assert property (post7 && !is_pm && lin && !cur_m[31]
        && sum >= cur_b |=> sticky_status_reg[0]) else $error("zero length hid overflow");
    a_sticky_clear: assert property (sticky_status_reg[0] && dm_acc && ix == 3'h7 && !ovf_dm7
        |=> !sticky_status_reg[0]) else $error("sticky not cleared");
    a_brev_strobes: assert property (brev_op |=> o_dm_bank_sel == 4'h1
        && !o_dm_rd && !o_dm_wr) else $error("reverse op strobed memory");
    a_index0_plain: assert property (take && k_post && brev_mode && lin
        |=> dm_i_reg[0] == $past(sum)) else $error("index 0 stored reversed");
    a_last_addr: assert property (dm_acc |=> dm_last_reg == o_dm_addr)
        else $error("last address mismatch");
    a_stall_once: assert property (o_stall |=> !o_stall)
        else $error("stall longer than one cycle");
    a_pm_ctl_gap: assert property (ctl_wr && is_pm |=> o_stall)
        else $error("no gap after pm control write");
    a_base_index: assert property (reg_wr && !is_pm && i_op.rclass == RC_B
        |=> dm_i_reg[$past(ix)] == $past(wr_val)) else $error("base did not load index");
    a_pre_hold: assert property (take && k_pre && !is_pm
        |=> dm_i_reg[$past(ix)] == $past(cur_i)) else $error("pre-modify wrote index");
    c_dm_irq: cover property (o_dm_ring_wrap_irq);
    c_brev: cover property (brev_op ##1 o_dm_bank_sel == 4'h1);
    c_stall: cover property (reg_wr ##1 o_stall);
    c_pm_wrap: cover property (ovf_pm15 && over);
endmodule : dag_top
`default_nettype wire

// ---- bench/dag_seq_model.sv ----
// Purpose: sequencer model that offers ops and data words to the generators
// Assumes: ops are offered right after a rising edge of the core clock
// Notes: an op is held unchanged while the generators stall it
`default_nettype none
module dag_seq_model
    import dag_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // generator handshake
    input wire logic i_stall,
    output var logic o_op_valid,
    output var dag_pkg::dag_op_t o_op,
    output var logic [dag_pkg::BUS_W-1:0] o_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_op_valid = 1'b0;
        o_op = '0;
        o_data = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // returns at the edge that takes the op, valid still high for back-to-back use
    task automatic issue(input dag_op_t op, input logic [BUS_W-1:0] din, output int stalls);
        logic taken;
        stalls = 0;
        o_op_valid <= 1'b1;
        o_op <= op;
        o_data <= din;
        do begin
            @(negedge i_clk_sys);
            taken = !i_stall;
            if (!taken) stalls++;
            @(posedge i_clk_sys);
        end while (!taken);
    endtask : issue

    // an empty slot after every op keeps addressing ops clear of stalls from register or control writes
    task automatic idle();
        o_op_valid <= 1'b0;
        o_data <= ~o_data;
    endtask : idle
endmodule : dag_seq_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: self-checking bench of the dual address generator
// Assumes: ops come from the sequencer model, registers over axi4-lite
// Notes: expected values are worked out by hand from the ring and reversal arithmetic
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import dag_pkg::*;

    typedef struct {dag_op_t op; logic [39:0] din; logic [39:0] exp; logic irq;} dag_row_t;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_op_valid, o_stall, o_dm_rd, o_dm_wr, o_pm_rd, o_pm_wr;
    dag_op_t i_op;
    logic [39:0] i_dm_data_bus, o_dm_data_bus;
    logic [31:0] o_dm_addr, o_s_axi_rdata, rd;
    logic [23:0] o_pm_addr;
    logic [3:0] o_dm_bank_sel;
    logic [2:0] o_dm_wait, o_pm_wait;
    logic o_dm_ring_wrap_irq, o_pm_ring_wrap_irq;
    logic [7:0] i_s_axi_awaddr = 8'h00, i_s_axi_araddr = 8'h00;
    logic [31:0] i_s_axi_wdata = 32'h0;
    logic [3:0] i_s_axi_wstrb = 4'h0;
    logic i_s_axi_awvalid = 1'b0, i_s_axi_wvalid = 1'b0, i_s_axi_bready = 1'b0;
    logic i_s_axi_arvalid = 1'b0, i_s_axi_rready = 1'b0;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp, rs;
    int cycles = 0, miscompares = 0, num_checks = 0, st;
    dag_row_t rows[$];

    always #5 i_clk_sys = ~i_clk_sys;

    dag_top dag_top_i (.i_clk_sys, .i_sys_rst, .i_op_valid, .i_op, .o_stall, .i_dm_data_bus,
        .o_dm_data_bus, .o_dm_addr, .o_dm_rd, .o_dm_wr, .o_dm_bank_sel, .o_dm_wait, .o_pm_addr,
        .o_pm_rd, .o_pm_wr, .o_pm_wait, .o_dm_ring_wrap_irq, .o_pm_ring_wrap_irq,
        .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
        .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
        .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
        .o_s_axi_rvalid, .i_s_axi_rready);
    dag_seq_model dag_seq_model_i (.i_clk_sys, .i_stall(o_stall), .o_op_valid(i_op_valid),
        .o_op(i_op), .o_data(i_dm_data_bus));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    function automatic dag_op_t mkop(dag_kind_t k, logic p, logic [2:0] i, logic [2:0] m,
                                     logic [31:0] imm, dag_rclass_t rc);
        return '{k, p, 1'b0, i, m, imm != 32'h0, imm, rc};
    endfunction : mkop

    // leaves at the falling edge of the cycle in which the op's outputs stand
    task automatic step(input dag_op_t op, input logic [39:0] din, output int s);
        @(posedge i_clk_sys);
        dag_seq_model_i.issue(op, din, s);
        dag_seq_model_i.idle();
        @(negedge i_clk_sys);
    endtask : step

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw;
        logic w;
        logic b;
        @(posedge i_clk_sys);
        i_s_axi_awaddr <= a;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wdata <= d;
        i_s_axi_wstrb <= 4'hf;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        do begin
            @(negedge i_clk_sys);
            aw = i_s_axi_awvalid && o_s_axi_awready;
            w = i_s_axi_wvalid && o_s_axi_wready;
            b = o_s_axi_bvalid;
            r = o_s_axi_bresp;
            @(posedge i_clk_sys);
            if (aw) i_s_axi_awvalid <= 1'b0;
            if (w) i_s_axi_wvalid <= 1'b0;
        end while (!b);
        i_s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        logic got;
        @(posedge i_clk_sys);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do begin
            @(negedge i_clk_sys);
            ar = i_s_axi_arvalid && o_s_axi_arready;
            got = o_s_axi_rvalid;
            d = o_s_axi_rdata;
            r = o_s_axi_rresp;
            @(posedge i_clk_sys);
            if (ar) i_s_axi_arvalid <= 1'b0;
        end while (!got);
        i_s_axi_rready <= 1'b0;
    endtask : axi_rd

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        // dm ring: base 0x100, length 0x10, step 8; pm ring 15 with zero length
        rows.push_back('{mkop(K_WRREG, 1'b0, 3'h7, 3'h0, 32'h0, RC_B), 40'h1_0000, 40'h0, 1'b0});
        rows.push_back('{mkop(K_WRREG, 1'b0, 3'h7, 3'h0, 32'h0, RC_L), 40'h1000, 40'h0, 1'b0});
        rows.push_back('{mkop(K_WRREG, 1'b0, 3'h1, 3'h0, 32'h0, RC_M), 40'h800, 40'h0, 1'b0});
        rows.push_back('{mkop(K_RDREG, 1'b0, 3'h7, 3'h0, 32'h0, RC_I), 40'h0, 40'h1_0000, 1'b0});
        rows.push_back('{mkop(K_POST, 1'b0, 3'h7, 3'h1, 32'h0, RC_I), 40'h0, 40'h100, 1'b0});
        rows.push_back('{mkop(K_POST, 1'b0, 3'h7, 3'h1, 32'h0, RC_I), 40'h0, 40'h108, 1'b1});
        rows.push_back('{mkop(K_PRE, 1'b0, 3'h7, 3'h1, 32'h0, RC_I), 40'h0, 40'h108, 1'b0});
        rows.push_back('{mkop(K_POST, 1'b0, 3'h7, 3'h0, 32'hffff_fffc, RC_I), 40'h0, 40'h100, 1'b1});
        rows.push_back('{mkop(K_RDREG, 1'b0, 3'h7, 3'h0, 32'h0, RC_I), 40'h0, 40'h1_0c00, 1'b0});
        rows.push_back('{mkop(K_WRREG, 1'b1, 3'h7, 3'h0, 32'h0, RC_B), 40'haa_0002_0000, 40'h0, 1'b0});
        rows.push_back('{mkop(K_WRREG, 1'b1, 3'h2, 3'h0, 32'h0, RC_M), 40'h55_ffff_ff00, 40'h0, 1'b0});
        rows.push_back('{mkop(K_RDREG, 1'b1, 3'h2, 3'h0, 32'h0, RC_M), 40'h0, 40'hff_ffff_ff00, 1'b0});
        rows.push_back('{mkop(K_RDREG, 1'b1, 3'h7, 3'h0, 32'h0, RC_B), 40'h0, 40'h2_0000, 1'b0});
        rows.push_back('{mkop(K_POST, 1'b1, 3'h7, 3'h2, 32'h0, RC_I), 40'h0, 40'h200, 1'b1});
        rows.push_back('{mkop(K_RDREG, 1'b1, 3'h7, 3'h0, 32'h0, RC_I), 40'h0, 40'h1_ff00, 1'b0});
        rows.push_back('{mkop(K_BREV, 1'b0, 3'h1, 3'h0, 32'h4, RC_I), 40'h0, 40'h2000_0000, 1'b0});
        rows.push_back('{mkop(K_RDREG, 1'b0, 3'h1, 3'h0, 32'h0, RC_I), 40'h0, 40'h20_0000_0000, 1'b0});
        repeat (6) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        axi_rd(OFS_MODE, rd, rs);
        chk("mode", RST_MODE, rd);
        axi_rd(OFS_MASK, rd, rs);
        chk("mask", RST_MASK, rd);
        axi_wr(OFS_STICKY_STATUS, 32'hffff_ffff, rs);
        axi_rd(OFS_STICKY_STATUS, rd, rs);
        chk("sticky", 32'h0, rd);
        axi_rd(8'h40, rd, rs);
        chk("rresp", AXI_SLVERR, rs);
        axi_wr(OFS_MASK, (32'h1 << MASK_DM_BIT) | (32'h1 << MASK_PM_BIT), rs);
        chk("bresp", AXI_OKAY, rs);
        foreach (rows[n]) begin
            step(rows[n].op, rows[n].din, st);
            if (rows[n].op.kind == K_RDREG) begin
                chk("data", rows[n].exp, o_dm_data_bus);
            end else if (rows[n].op.kind != K_WRREG) begin
                chk("addr", rows[n].exp, rows[n].op.pm ? {16'h0, o_pm_addr} : {8'h0, o_dm_addr});
                chk("strobe", rows[n].op.kind != K_BREV, rows[n].op.pm ? o_pm_rd : o_dm_rd);
                chk("irq", rows[n].irq, rows[n].op.pm ? o_pm_ring_wrap_irq : o_dm_ring_wrap_irq);
                chk("other irq", 1'b0, rows[n].op.pm ? o_dm_ring_wrap_irq : o_pm_ring_wrap_irq);
            end
        end
        axi_rd(OFS_STICKY_STATUS, rd, rs);
        chk("sticky", 32'h0006_0000, rd);
        step(mkop(K_PRE, 1'b0, 3'h7, 3'h1, 32'h0, RC_I), 40'h0, st);
        axi_rd(OFS_STICKY_STATUS, rd, rs);
        chk("sticky", 32'h0004_0000, rd);
        // masked overflow still marks the sticky bit
        axi_wr(OFS_MASK, 32'h1 << MASK_PM_BIT, rs);
        step(mkop(K_POST, 1'b0, 3'h7, 3'h1, 32'h0, RC_I), 40'h0, st);
        chk("masked irq", 1'b0, o_dm_ring_wrap_irq);
        axi_rd(OFS_STICKY_STATUS, rd, rs);
        chk("sticky", 32'h0006_0000, rd);
        axi_wr(OFS_MODE, 32'h1 << MODE_BR0_BIT, rs);
        step(mkop(K_WRCTL, 1'b0, 3'h0, 3'h0, 32'h0, RC_I), 40'h8500, st);
        step(mkop(K_WRREG, 1'b0, 3'h0, 3'h0, 32'h0, RC_I), 40'h80_4000_0000, st);
        step(mkop(K_POST, 1'b0, 3'h0, 3'h0, 32'h3, RC_I), 40'h0, st);
        chk("rev addr", 32'h0000_0201, o_dm_addr);
        chk("bank", 4'h1, o_dm_bank_sel);
        chk("wait", 3'h5, o_dm_wait);
        step(mkop(K_RDREG, 1'b0, 3'h0, 3'h0, 32'h0, RC_I), 40'h0, st);
        chk("index0", 40'h80_4000_0300, o_dm_data_bus);
        axi_rd(OFS_DM_LAST, rd, rs);
        chk("last addr", 32'h0000_0201, rd);
        @(posedge i_clk_sys);
        dag_seq_model_i.issue(mkop(K_WRREG, 1'b0, 3'h3, 3'h0, 32'h0, RC_M), 40'h0, st);
        dag_seq_model_i.issue(mkop(K_PRE, 1'b0, 3'h2, 3'h3, 32'h0, RC_I), 40'h0, st);
        chk("stall", 1, st);
        dag_seq_model_i.issue(mkop(K_WRCTL, 1'b1, 3'h0, 3'h0, 32'h0, RC_I), 40'h0, st);
        dag_seq_model_i.issue(mkop(K_RDREG, 1'b0, 3'h1, 3'h0, 32'h0, RC_I), 40'h0, st);
        chk("stall", 1, st);
        dag_seq_model_i.issue(mkop(K_WRCTL, 1'b0, 3'h0, 3'h0, 32'h0, RC_I), 40'h0, st);
        dag_seq_model_i.issue(mkop(K_PRE, 1'b0, 3'h2, 3'h3, 32'h0, RC_I), 40'h0, st);
        chk("stall", 1, st);
        dag_seq_model_i.idle();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
